// ===== rtl/etm_params.svh
// Purpose: named offsets, fields, reset values and counts of the timer
// Assumes: 32-bit Avalon-MM data, byte addresses
// Notes:   definitions only
`ifndef ETM_PARAMS_SVH
`define ETM_PARAMS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define ETM_OFS_CTRL      8'h00
`define ETM_OFS_CMPA      8'h04
`define ETM_OFS_CMPB      8'h08
`define ETM_OFS_STAT      8'h0c
`define ETM_OFS_COUNT     8'h10

// ****************************************
// control register field positions
// ****************************************
`define ETM_F_AMODE_LO    0
`define ETM_F_AMODE_HI    1
`define ETM_F_BMODE_LO    2
`define ETM_F_BMODE_HI    3
`define ETM_F_AFUNC_LO    4
`define ETM_F_AFUNC_HI    5
`define ETM_F_BFUNC_LO    6
`define ETM_F_BFUNC_HI    7
`define ETM_F_ALIGN_LO    8
`define ETM_F_ALIGN_HI    9
`define ETM_F_CLRSEL      10
`define ETM_F_RUN         11
`define ETM_F_CODE_LO     12
`define ETM_F_CODE_HI     14
`define ETM_F_AINIT       15
`define ETM_F_BINIT       16
`define ETM_F_APOL        17
`define ETM_F_BPOL        18
`define ETM_CTRL_W        19

// status flag positions
`define ETM_F_FLAG_A      0
`define ETM_F_FLAG_B      1
`define ETM_F_FLAG_P      2

// ****************************************
// field encodings and values
// ****************************************
`define ETM_MODE_PWM      2'h2
`define ETM_MODE_CAP      2'h1
`define ETM_FUNC_LOW      2'h0
`define ETM_FUNC_HIGH     2'h1
`define ETM_FUNC_WAVE     2'h2
`define ETM_FUNC_PULSE    2'h3
`define ETM_EDGE_RISE     2'h0
`define ETM_EDGE_FALL     2'h1
`define ETM_EDGE_BOTH     2'h2
`define ETM_ALIGN_CENTRE  2'h3
`define ETM_CODE_SHIFT    7
`define ETM_EDGE_ZERO_PER 11'h400
`define ETM_CTR_ZERO_HALF 10'h3ff
`define ETM_CTRL_RST      19'h00000
`define ETM_CMP_RST       10'h000

`endif

// ===== rtl/etm_pkg.sv
// Purpose: types shared by the timer
// Assumes: nothing
// Notes:   operating modes decoded from the mode and pin-function fields
package etm_pkg;

  typedef enum logic [1:0] {
    ETM_OP_IDLE  = 2'b00,
    ETM_OP_PWM   = 2'b01,
    ETM_OP_PULSE = 2'b10,
    ETM_OP_CAP   = 2'b11
  } etm_op_e;

  typedef logic [31:0] etm_word_t;

endpackage

// ===== rtl/etm_timer.sv
// Purpose: PWM, single pulse and input capture timer with Avalon-MM slave
// Assumes: pins synchronous to mclk_i; en_i low freezes everything
// Notes:   one wait state on every bus access
`timescale 1ns/10ps
`default_nettype none
`include "etm_params.svh"

// Operation
// - duty at or above period gives 100%
// - edge, clear select: period A, duty B
// - centre, coarse: period 256 x code, 2046
// - centre, clear select: period 2xA, duty 2xB-1
// - alignment field 11 selects centre PWM
// - waveform keeps running while pin forced
// - centre: period flag when counting down zero
// - run rise starts counter and pulse A
// - comparator B match starts pulse B
// - trigger pin edge sets run bit
// - A match or run clear ends pulses
// - A and B matches raise flags
// - pulse counter zeroed only on run rise
// - capture mode 01, run rise starts counter
// - active pin edge captures counter, flags
// - capture: free run, coarse match wraps, flags
// - coarse code zero wraps at maximum count
// - edge select 11 disables channel capture
// - capture works even if pin drives
// - capture ignores clear select, levels, polarity
module etm_timer
  import etm_pkg::*;
#(
  parameter int CNT_W = 10
)(
  input  wire logic             mclk_i,
  input  wire logic             rst_b_i,
  input  wire logic             en_i,
  input  wire logic [7:0]       avs_address_i,
  input  wire logic             avs_read_i,
  input  wire logic             avs_write_i,
  input  wire etm_pkg::etm_word_t avs_writedata_i,
  output var  etm_pkg::etm_word_t avs_readdata_o,
  output var  logic             avs_waitrequest_o,
  input  wire logic             channel_a_pin_i,
  input  wire logic             channel_b_pin_first_i,
  input  wire logic             external_trigger_pin_i,
  output var  logic             channel_a_pin_o,
  output var  logic             channel_a_pin_oe_o,
  output var  logic             channel_b_pin_first_o,
  output var  logic             channel_b_pin_second_o,
  output var  logic             channel_b_pin_oe_o
);
  import etm_pkg::*;

  // ****************************************
  // registers and decode
  // ****************************************
  logic [`ETM_CTRL_W-1:0] ctrl_q;
  logic [CNT_W-1:0]       cmpa_q;
  logic [CNT_W-1:0]       cmpb_q;
  logic [2:0]             flag_q;
  logic [CNT_W-1:0]       cnt_q;
  logic                   down_q;
  logic                   run_prev_q;
  logic                   pulse_b_q;
  logic                   pin_a_prev_q;
  logic                   pin_b_prev_q;
  logic                   trig_prev_q;
  logic                   wait_q;
  etm_word_t              rdata_q;
  etm_op_e                op;

  logic [1:0] a_mode;
  logic [1:0] b_mode;
  logic [1:0] a_func;
  logic [1:0] b_func;
  logic       centre;
  logic       clr_sel;
  logic       run;
  logic [2:0] code;
  logic       acc_wr;
  logic       run_rise;
  logic       trig_rise;

  assign a_mode  = ctrl_q[`ETM_F_AMODE_HI:`ETM_F_AMODE_LO];
  assign b_mode  = ctrl_q[`ETM_F_BMODE_HI:`ETM_F_BMODE_LO];
  assign a_func  = ctrl_q[`ETM_F_AFUNC_HI:`ETM_F_AFUNC_LO];
  assign b_func  = ctrl_q[`ETM_F_BFUNC_HI:`ETM_F_BFUNC_LO];
  assign centre  = (ctrl_q[`ETM_F_ALIGN_HI:`ETM_F_ALIGN_LO] == `ETM_ALIGN_CENTRE);
  assign clr_sel = ctrl_q[`ETM_F_CLRSEL];
  assign run     = ctrl_q[`ETM_F_RUN];
  assign code    = ctrl_q[`ETM_F_CODE_HI:`ETM_F_CODE_LO];
  assign acc_wr  = en_i && avs_write_i && !wait_q;
  assign run_rise  = run && !run_prev_q;
  assign trig_rise = external_trigger_pin_i && !trig_prev_q;

  // mode decode from both channel fields
  always_comb
  begin
    op = ETM_OP_IDLE;
    if ((a_mode == `ETM_MODE_CAP) && (b_mode == `ETM_MODE_CAP))
      op = ETM_OP_CAP;
    else if ((a_mode == `ETM_MODE_PWM) && (b_mode == `ETM_MODE_PWM))
    begin
      if ((a_func == `ETM_FUNC_PULSE) && (b_func == `ETM_FUNC_PULSE))
        op = ETM_OP_PULSE;
      else
        op = ETM_OP_PWM;
    end
  end

  // ****************************************
  // period, half period and duty compare
  // ****************************************
  logic [10:0]      edge_per;
  logic [CNT_W-1:0] half;
  logic [CNT_W-1:0] cap_lim;
  logic [10:0]      cnt_ext;
  logic             edge_wrap;
  logic             act_a;
  logic             act_b;
  logic             match_a;
  logic             match_b;

  assign cnt_ext = {1'b0, cnt_q};

  always_comb
  begin
    if (clr_sel)
      edge_per = {1'b0, cmpa_q};
    else if (code == 3'h0)
      edge_per = `ETM_EDGE_ZERO_PER;
    else
      edge_per = 11'(code) << `ETM_CODE_SHIFT;
    if (clr_sel)
      half = cmpa_q;
    else if (code == 3'h0)
      half = `ETM_CTR_ZERO_HALF;
    else
      half = CNT_W'(code) << `ETM_CODE_SHIFT;
    if (code == 3'h0)
      cap_lim = {CNT_W{1'b1}};
    else
      cap_lim = (CNT_W'(code) << `ETM_CODE_SHIFT) - CNT_W'(1);
  end

  assign edge_wrap = (cnt_ext + 11'h001) >= edge_per;
  assign match_a   = (cnt_q == cmpa_q);
  assign match_b   = (cnt_q == cmpb_q);

  // active phase: counter below duty; duty at or above period means always
  always_comb
  begin
    if (centre)
    begin
      act_a = (cmpa_q >= half) || (cnt_q < cmpa_q);
      act_b = (cmpb_q >= half) || (cnt_q < cmpb_q);
    end
    else
    begin
      act_a = ({1'b0, cmpa_q} >= edge_per) || (cnt_q < cmpa_q);
      act_b = ({1'b0, cmpb_q} >= edge_per) || (cnt_q < cmpb_q);
    end
    if (clr_sel)
      act_a = 1'b0;
  end

  // ****************************************
  // counter
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_q  <= `ETM_CMP_RST;
      down_q <= 1'b0;
    end
    else if (en_i)
    begin
      if (!run || run_rise || (op == ETM_OP_IDLE))
      begin
        if (run_rise)
          cnt_q <= `ETM_CMP_RST;
        down_q <= 1'b0;
      end
      else
      begin
        case (op)
          ETM_OP_PWM:
          begin
            if (centre)
            begin
              if (!down_q)
              begin
                cnt_q <= cnt_q + CNT_W'(1);
                if ((cnt_q + CNT_W'(1)) >= half)
                  down_q <= 1'b1;
              end
              else
              begin
                cnt_q <= cnt_q - CNT_W'(1);
                if (cnt_q <= CNT_W'(1))
                  down_q <= 1'b0;
              end
            end
            else if (edge_wrap)
              cnt_q <= `ETM_CMP_RST;
            else
              cnt_q <= cnt_q + CNT_W'(1);
          end
          ETM_OP_PULSE:
          begin
            if (cnt_q != {CNT_W{1'b1}})
              cnt_q <= cnt_q + CNT_W'(1);
          end
          ETM_OP_CAP:
          begin
            if (cnt_q == cap_lim)
              cnt_q <= `ETM_CMP_RST;
            else
              cnt_q <= cnt_q + CNT_W'(1);
          end
          default:
            cnt_q <= cnt_q;
        endcase
      end
    end
  end

  // ****************************************
  // edge history of pins and run bit
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      run_prev_q   <= 1'b0;
      pin_a_prev_q <= 1'b0;
      pin_b_prev_q <= 1'b0;
      trig_prev_q  <= 1'b0;
    end
    else if (en_i)
    begin
      run_prev_q   <= run;
      pin_a_prev_q <= channel_a_pin_i;
      pin_b_prev_q <= channel_b_pin_first_i;
      trig_prev_q  <= external_trigger_pin_i;
    end
  end

  // ****************************************
  // capture events, per channel
  // ****************************************
  logic [1:0] cap_pin;
  logic [1:0] cap_prev;
  logic [1:0] cap_sel [2];
  logic [1:0] cap_hit;

  assign cap_pin    = {channel_b_pin_first_i, channel_a_pin_i};
  assign cap_prev   = {pin_b_prev_q, pin_a_prev_q};
  assign cap_sel[0] = a_func;
  assign cap_sel[1] = b_func;

  // pin sampled regardless of its drive direction
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_cap
      always_comb
      begin
        cap_hit[gi] = 1'b0;
        if ((op == ETM_OP_CAP) && run)
        begin
          case (cap_sel[gi])
            `ETM_EDGE_RISE: cap_hit[gi] = cap_pin[gi] && !cap_prev[gi];
            `ETM_EDGE_FALL: cap_hit[gi] = !cap_pin[gi] && cap_prev[gi];
            `ETM_EDGE_BOTH: cap_hit[gi] = cap_pin[gi] ^ cap_prev[gi];
            default:        cap_hit[gi] = 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // ****************************************
  // event flags
  // ****************************************
  logic [2:0] flag_set;

  always_comb
  begin
    flag_set = 3'h0;
    if (run && !run_rise)
    begin
      case (op)
        ETM_OP_PWM:
        begin
          flag_set[`ETM_F_FLAG_A] = match_a;
          flag_set[`ETM_F_FLAG_B] = match_b;
          if (centre)
            flag_set[`ETM_F_FLAG_P] = down_q && (cnt_q == CNT_W'(1));
          else
            flag_set[`ETM_F_FLAG_P] = edge_wrap && !clr_sel;
        end
        ETM_OP_PULSE:
        begin
          flag_set[`ETM_F_FLAG_A] = match_a;
          flag_set[`ETM_F_FLAG_B] = match_b;
        end
        ETM_OP_CAP:
        begin
          flag_set[`ETM_F_FLAG_A] = cap_hit[0];
          flag_set[`ETM_F_FLAG_B] = cap_hit[1];
          flag_set[`ETM_F_FLAG_P] = (cnt_q == cap_lim);
        end
        default:
          flag_set = 3'h0;
      endcase
    end
  end

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      flag_q <= 3'h0;
    else if (en_i)
    begin
      if (acc_wr && (avs_address_i == `ETM_OFS_STAT))
        flag_q <= (flag_q & ~avs_writedata_i[2:0]) | flag_set;
      else
        flag_q <= flag_q | flag_set;
    end
  end

  // ****************************************
  // control register, run bit automation
  // ****************************************
  logic pulse_end;

  assign pulse_end = (op == ETM_OP_PULSE) && run && !run_rise && match_a;

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      ctrl_q <= `ETM_CTRL_RST;
    else if (en_i)
    begin
      if (acc_wr && (avs_address_i == `ETM_OFS_CTRL))
        ctrl_q <= avs_writedata_i[`ETM_CTRL_W-1:0];
      if ((op == ETM_OP_PULSE) && trig_rise && !run)
        ctrl_q[`ETM_F_RUN] <= 1'b1;
      else if (pulse_end)
        ctrl_q[`ETM_F_RUN] <= 1'b0;
    end
  end

  // ****************************************
  // compare registers, loaded by capture too
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cmpa_q <= `ETM_CMP_RST;
      cmpb_q <= `ETM_CMP_RST;
    end
    else if (en_i)
    begin
      if (cap_hit[0])
        cmpa_q <= cnt_q;
      else if (acc_wr && (avs_address_i == `ETM_OFS_CMPA))
        cmpa_q <= avs_writedata_i[CNT_W-1:0];
      if (cap_hit[1])
        cmpb_q <= cnt_q;
      else if (acc_wr && (avs_address_i == `ETM_OFS_CMPB))
        cmpb_q <= avs_writedata_i[CNT_W-1:0];
    end
  end

  // ****************************************
  // single pulse channel B state
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      pulse_b_q <= 1'b0;
    else if (en_i)
    begin
      if (!run || run_rise || pulse_end || (op != ETM_OP_PULSE))
        pulse_b_q <= 1'b0;
      else if (match_b)
        pulse_b_q <= 1'b1;
    end
  end

  // ****************************************
  // pin outputs
  // ****************************************
  logic lvl_a;
  logic lvl_b;
  logic wave_a;
  logic wave_b;

  // active level follows initial level, then optional inversion
  assign wave_a = (act_a == ctrl_q[`ETM_F_AINIT]) ^ ctrl_q[`ETM_F_APOL];
  assign wave_b = (act_b == ctrl_q[`ETM_F_BINIT]) ^ ctrl_q[`ETM_F_BPOL];

  always_comb
  begin
    lvl_a = 1'b0;
    lvl_b = 1'b0;
    case (op)
      ETM_OP_PWM:
      begin
        case (a_func)
          `ETM_FUNC_LOW:  lvl_a = 1'b0;
          `ETM_FUNC_HIGH: lvl_a = 1'b1;
          default:        lvl_a = wave_a;
        endcase
        case (b_func)
          `ETM_FUNC_LOW:  lvl_b = 1'b0;
          `ETM_FUNC_HIGH: lvl_b = 1'b1;
          default:        lvl_b = wave_b;
        endcase
      end
      ETM_OP_PULSE:
      begin
        lvl_a = ((run && !run_rise) == ctrl_q[`ETM_F_AINIT]) ^ ctrl_q[`ETM_F_APOL];
        lvl_b = (pulse_b_q == ctrl_q[`ETM_F_BINIT]) ^ ctrl_q[`ETM_F_BPOL];
      end
      default:
      begin
        lvl_a = 1'b0;
        lvl_b = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      channel_a_pin_o        <= 1'b0;
      channel_a_pin_oe_o     <= 1'b0;
      channel_b_pin_first_o  <= 1'b0;
      channel_b_pin_second_o <= 1'b0;
      channel_b_pin_oe_o     <= 1'b0;
    end
    else if (en_i)
    begin
      channel_a_pin_o        <= lvl_a;
      channel_a_pin_oe_o     <= (op == ETM_OP_PULSE) || ((op == ETM_OP_PWM) && !clr_sel);
      channel_b_pin_first_o  <= lvl_b;
      channel_b_pin_second_o <= lvl_b;
      channel_b_pin_oe_o     <= (op == ETM_OP_PULSE) || (op == ETM_OP_PWM);
    end
  end

  // ****************************************
  // Avalon-MM slave, one wait state
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end
    else if (en_i)
    begin
      if ((avs_read_i || avs_write_i) && wait_q)
      begin
        wait_q <= 1'b0;
        case (avs_address_i)
          `ETM_OFS_CTRL:  rdata_q <= 32'(ctrl_q);
          `ETM_OFS_CMPA:  rdata_q <= 32'(cmpa_q);
          `ETM_OFS_CMPB:  rdata_q <= 32'(cmpb_q);
          `ETM_OFS_STAT:  rdata_q <= 32'(flag_q);
          `ETM_OFS_COUNT: rdata_q <= 32'(cnt_q);
          default:        rdata_q <= 32'h0000_0000;
        endcase
      end
      else
        wait_q <= 1'b1;
    end
  end

  assign avs_readdata_o    = rdata_q;
  assign avs_waitrequest_o = wait_q;

endmodule
`default_nettype wire

// ===== tb/etm_timer_checker.sv
// Purpose: port-level checks of the timer
// Assumes: control word shadowed from accepted bus writes
// Notes:   bound to etm_timer at the foot
`timescale 1ns/10ps
`default_nettype none
`include "etm_params.svh"
module etm_timer_checker
  import etm_pkg::*;
#(
  parameter int CNT_W = 10
)(
  input wire logic               mclk_i,
  input wire logic               rst_b_i,
  input wire logic               en_i,
  input wire logic [7:0]         avs_address_i,
  input wire logic               avs_read_i,
  input wire logic               avs_write_i,
  input wire etm_pkg::etm_word_t avs_writedata_i,
  input wire etm_pkg::etm_word_t avs_readdata_o,
  input wire logic               avs_waitrequest_o,
  input wire logic               channel_a_pin_o,
  input wire logic               channel_a_pin_oe_o,
  input wire logic               channel_b_pin_first_o,
  input wire logic               channel_b_pin_second_o,
  input wire logic               channel_b_pin_oe_o
);
  // ****************************************
  // control shadow
  // ****************************************
  logic [18:0] ctrl_q;
  logic [1:0]  age_q;
  logic        acc, cap, pls, pwm, ok;
  assign acc = avs_write_i && !avs_waitrequest_o && en_i && avs_address_i == `ETM_OFS_CTRL;
  assign cap = ctrl_q[3:0] == 4'h5;
  assign pls = ctrl_q[7:0] == 8'hfa;
  assign pwm = ctrl_q[3:0] == 4'ha && !pls;
  assign ok  = age_q == 2'h3;
  always_ff @(posedge mclk_i or negedge rst_b_i)
    if (!rst_b_i) ctrl_q <= '0;
    else if (acc) ctrl_q <= avs_writedata_i[18:0];
  // cycles since the last control write
  always_ff @(posedge mclk_i or negedge rst_b_i)
    if (!rst_b_i) age_q <= 2'h0;
    else if (acc) age_q <= 2'h0;
    else if (en_i && !ok) age_q <= age_q + 2'h1;
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  a_wait_drop: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o && en_i
    |=> !avs_waitrequest_o) else $error("no answer after one wait state");
  a_wait_back: assert property (!avs_waitrequest_o && en_i |=> avs_waitrequest_o)
    else $error("wait request not raised again");
  a_unmapped_zero: assert property (avs_read_i && avs_waitrequest_o && en_i
    && avs_address_i > 8'h13 |=> avs_readdata_o == '0) else $error("unmapped read not zero");
  a_en_freeze: assert property (!en_i |=> $stable({avs_waitrequest_o, channel_a_pin_o,
    channel_b_pin_first_o})) else $error("outputs moved while disabled");
  a_cap_no_drive: assert property (ok && cap |-> !channel_a_pin_oe_o && !channel_b_pin_oe_o)
    else $error("pin driven in capture mode");
  a_pwm_b_drive: assert property (ok && pwm |-> channel_b_pin_oe_o)
    else $error("channel b not driven in pwm");
  a_pwm_a_drive: assert property (ok && pwm |-> channel_a_pin_oe_o == !ctrl_q[10])
    else $error("channel a drive wrong in pwm");
  a_force_level: assert property (ok && pwm && !ctrl_q[7]
    |-> channel_b_pin_first_o == ctrl_q[6]) else $error("forced level wrong");
  a_b_pins_equal: assert property (channel_b_pin_first_o == channel_b_pin_second_o)
    else $error("b pins differ");
  a_pulse_lead: assert property (acc && avs_writedata_i[7:0] == 8'hfa && avs_writedata_i[11]
    && !ctrl_q[11] |-> ##[1:3] channel_a_pin_o == (ctrl_q[15] ^ ctrl_q[17]))
    else $error("pulse a did not start");
endmodule
bind etm_timer etm_timer_checker #(.CNT_W(CNT_W)) i_chk (.*);
`default_nettype wire

// ===== tb/etm_pin_model.sv
// Purpose: external sources on capture and trigger pins
// Assumes: pins sampled on mclk_i
// Notes:   driven just after a rising edge
`timescale 1ns/10ps
`default_nettype none
module etm_pin_model (
  input  wire logic mclk_i,
  output var  logic cap_a_o,
  output var  logic cap_b_o,
  output var  logic trig_o
);
  initial
  begin
    cap_a_o = 1'b0;
    cap_b_o = 1'b0;
    trig_o  = 1'b0;
  end
  task automatic drive(input logic a, input logic b);
    @(posedge mclk_i);
    cap_a_o <= a;
    cap_b_o <= b;
  endtask
  // one-cycle rising edge on the trigger pin
  task automatic fire();
    @(posedge mclk_i);
    trig_o <= 1'b1;
    @(posedge mclk_i);
    trig_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Purpose: self-checking bench of the timer
// Assumes: one wait state per bus access, active level from init bit
// Notes:   pulse widths allow one cycle of slack
`timescale 1ns/10ps
`default_nettype none
`include "etm_params.svh"
module tb;
  import etm_pkg::*;
  logic        mclk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        en_i = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  etm_word_t   wd = '0;
  etm_word_t   rdata, q;
  logic        wait_o, a_o, a_oe, b1_o, b2_o, b_oe, pa, pb, trg;
  int          err_count = 0;
  int          num_checks = 0;
  int          seed = 32'h90c0;
  int unsigned mdl [6] = '{default: 0};
  int          ha, hb, c1, c2;
  etm_timer #(.CNT_W(10)) i_dut (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .en_i(en_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_o), .channel_a_pin_i(pa), .channel_b_pin_first_i(pb),
    .external_trigger_pin_i(trg), .channel_a_pin_o(a_o), .channel_a_pin_oe_o(a_oe),
    .channel_b_pin_first_o(b1_o), .channel_b_pin_second_o(b2_o), .channel_b_pin_oe_o(b_oe));
  etm_pin_model i_pins (.mclk_i(mclk_i), .cap_a_o(pa), .cap_b_o(pb), .trig_o(trg));
  always #2.5 mclk_i = ~mclk_i;
  // ****************************************
  // helpers
  // ****************************************
  task automatic complete_run();
    if (err_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input etm_word_t got, input etm_word_t exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic near(input int got, input int exp);
    chk({31'h0, got >= exp - 1 && got <= exp + 1}, 32'h1);
  endtask
  // holds the request until waitrequest is seen low; only the watchdog ends a hang
  task automatic bus(input logic w, input logic [7:0] a, input etm_word_t d);
    @(posedge mclk_i);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do
    begin
      @(posedge mclk_i);
    end
    while (wait_o !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wreg(input int i, input etm_word_t d);
    bus(1'b1, 8'(i * 4), d);
    if (i < 3) mdl[i] = d & (i == 0 ? 32'h7ffff : 32'h3ff);
  endtask
  task automatic rexp(input logic [7:0] a, input etm_word_t e);
    bus(1'b0, a, '0);
    chk(q, e);
  endtask
  // control word, both init levels high
  function automatic etm_word_t cw(input int m, f, al, cs, run, code);
    return etm_word_t'(m | (f << 4) | (al << 8) | (cs << 10) | (run << 11) | (code << 12)
      | 32'h18000);
  endfunction
  task automatic meas(input int n);
    ha = 0;
    hb = 0;
    repeat (n)
    begin
      @(posedge mclk_i);
      ha += int'(a_o === 1'b1);
      hb += int'(b1_o === 1'b1);
    end
  endtask
  task automatic pwm(input int ca, cb, input etm_word_t c, input int n, ea, eb);
    wreg(1, ca);
    wreg(2, cb);
    wreg(0, '0);
    wreg(0, c);
    repeat (40) @(posedge mclk_i);
    meas(n);
    chk(ha, ea);
    chk(hb, eb);
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial
  begin
    repeat (5) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    for (int i = 0; i < 5; i++) rexp(8'(i * 4), '0);
    wreg(5, 32'hffffffff);
    rexp(8'h14, '0);
    repeat (4)
    begin
      wreg(1, $random(seed));
      wreg(2, $random(seed));
      wreg(0, $random(seed) & 32'h7f7ff);
      for (int i = 0; i < 3; i++) rexp(8'(i * 4), mdl[i]);
    end
    wreg(0, '0);
    for (int e = 0; e < 4; e++)
    begin
      wreg(0, cw(5, e | 12, 0, 1, 1, 0) | 32'h60000);
      wreg(3, 32'h7);
      i_pins.drive(1'b1, 1'b1);
      repeat (4) @(posedge mclk_i);
      rexp(8'h0c, {31'h0, e == 0 || e == 2});
      wreg(3, 32'h7);
      i_pins.drive(1'b0, 1'b0);
      repeat (4) @(posedge mclk_i);
      rexp(8'h0c, {31'h0, e == 1 || e == 2});
    end
    wreg(0, cw(5, 0, 0, 0, 1, 0));
    bus(1'b0, 8'h10, '0);
    c1 = q;
    i_pins.drive(1'b1, 1'b0);
    bus(1'b0, 8'h10, '0);
    c2 = q;
    bus(1'b0, 8'h04, '0);
    chk({31'h0, q > c1 && q < c2}, 32'h1);
    wreg(0, '0);
    wreg(3, 32'h7);
    wreg(0, cw(5, 15, 0, 0, 1, 0));
    repeat (900) @(posedge mclk_i);
    rexp(8'h0c, '0);
    repeat (200) @(posedge mclk_i);
    rexp(8'h0c, 32'h4);
    wreg(0, '0);
    wreg(0, cw(5, 15, 0, 0, 1, 1));
    repeat (300) @(posedge mclk_i);
    bus(1'b0, 8'h10, '0);
    chk({31'h0, q < 128}, 32'h1);
    // pin a kept off while compare a sets the period
    pwm(10, 4, cw(10, 8, 0, 1, 1, 0), 50, 0, 20);
    pwm(10, 10, cw(10, 8, 0, 1, 1, 0), 50, 0, 50);
    pwm(30, 200, cw(10, 10, 0, 0, 1, 1), 128, 30, 128);
    pwm(30, 5, cw(10, 10, 3, 0, 1, 1), 256, 59, 9);
    pwm(20, 5, cw(10, 8, 3, 1, 1, 0), 80, 0, 18);
    pwm(30, 5, cw(10, 1, 3, 0, 1, 1), 256, 256, 0);
    wreg(3, 32'h7);
    repeat (300) @(posedge mclk_i);
    bus(1'b0, 8'h0c, '0);
    chk({31'h0, q[2]}, 32'h1);
    wreg(1, 40);
    wreg(2, 15);
    wreg(0, '0);
    wreg(3, 32'h7);
    wreg(0, cw(10, 15, 0, 0, 1, 0));
    meas(100);
    near(ha, 40);
    near(hb, 25);
    rexp(8'h0c, 32'h3);
    rexp(8'h00, mdl[0] ^ 32'h800);
    wreg(0, cw(10, 15, 0, 1, 0, 1));
    wreg(3, 32'h7);
    i_pins.fire();
    meas(100);
    near(ha, 40);
    near(hb, 25);
    rexp(8'h0c, 32'h3);
    wreg(0, cw(10, 15, 0, 0, 0, 0));
    wreg(0, cw(10, 15, 0, 0, 1, 0));
    repeat (20) @(posedge mclk_i);
    wreg(0, cw(10, 15, 0, 0, 0, 0));
    repeat (3) @(posedge mclk_i);
    chk({30'h0, a_o, b1_o}, 32'h0);
    en_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    en_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    complete_run();
  end
  initial
  begin
    #(30000 * 5);
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
